//--- test/acr_host_model.sv
// Purpose: host side of the register port
// Assumes: strobes one cycle wide, answer sampled one edge later
// Notes: released lines show inverted junk, not the last value
`timescale 1ns/1ps
module acr_host_model (
	input wire logic sys_clk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		@(posedge sys_clk);
		// Undefined low-byte bit is noise, so drop it
		v = reg_rdata & (a inside {8'h02, 8'h04, 8'h06} ? 8'hFD : 8'hFF);
	endtask
endmodule // acr_host_model

//--- test/acr_readout_assertions.sv
// Purpose: port checks of the accelerometer register readout
// Assumes: one access per strobe, read data one cycle after the strobe
// Notes: attached by bind from the bench
`timescale 1ns/1ps
module acr_readout_checker (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [7:0] temp_in,
	input wire logic [3:0] range_code,
	input wire logic [4:0] bw_code,
	input wire logic unfiltered_stream_select
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic soft_hit = reg_wr && reg_addr == 8'h14 && reg_wdata == 8'hB6;
	a_range_load: assert property (reg_wr && reg_addr == 8'h0F |=>
		{4'h0, range_code} == ($past(reg_wdata) & 8'h0F)) else $error("range");
	a_bw_load: assert property (reg_wr && reg_addr == 8'h10 |=>
		{3'h0, bw_code} == ($past(reg_wdata) & 8'h1F)) else $error("bw");
	a_stream_load: assert property (reg_wr && reg_addr == 8'h13 |=>
		unfiltered_stream_select == ($past(reg_wdata) > 8'h7F)) else $error("sel");
	a_soft_defaults: assert property (soft_hit |=> range_code == 4'h3 &&
		bw_code == 5'h0F && !unfiltered_stream_select) else $error("soft");
	a_cfg_steady: assert property (!reg_wr |=>
		$stable({range_code, bw_code, unfiltered_stream_select})) else $error("cfg");
	a_temp_read: assert property (reg_rd && reg_addr == 8'h08 &&
		$stable(temp_in) |=> reg_rdata == $past(temp_in)) else $error("temp");
	a_hole_zero: assert property (reg_rd && reg_addr > 8'h13 |=>
		reg_rdata == 8'h00) else $error("unmapped");
	a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("rdata moved");
	a_ctrl_spare: assert property (reg_rd && reg_addr == 8'h13 |=>
		reg_rdata[5:0] == 6'h00) else $error("ctrl spare");
endmodule // acr_readout_checker

//--- test/acr_readout_bench.sv
// Purpose: self-checking bench of the accelerometer register readout
// Assumes: unfiltered update every 20000 cycles
// Notes: low byte is read before high byte, except on the y axis
`timescale 1ns/1ps
module acr_readout_bench;
	import acr_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d, r;
	logic [7:0] temp_in = 8'h00;
	acr_sample_t fx, fy, fz, ux, uy, uz, s;
	logic [3:0] range_code;
	logic [4:0] bw_code;
	logic unfiltered_stream_select;
	logic sample_ready;
	time t_first;
	int n_errors = 0;
	int checks_done = 0;
	always #12.5 sys_clk = ~sys_clk;
	acr_readout acr_readout_inst (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata, .filt_x(fx), .filt_y(fy), .filt_z(fz),
		.unfilt_x(ux), .unfilt_y(uy), .unfilt_z(uz), .temp_in,
		.sample_ready, .range_code, .bw_code, .unfiltered_stream_select);
	acr_host_model acr_host_model_inst (.sys_clk, .reg_wr, .reg_rd, .reg_addr,
		.reg_wdata, .reg_rdata);
	function automatic acr_byte_t lo(acr_sample_t v, logic f);
		return {v[5:0], 1'b0, f};
	endfunction
	task automatic chk(string w, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		acr_host_model_inst.wr(a, v);
	endtask
	task automatic rdc(string w, logic [7:0] a, logic [7:0] e);
		acr_host_model_inst.rd(a, d);
		chk(w, e, d);
	endtask
	task automatic fresh();
		{ux, uy, uz, fx, fy, fz} <= 84'({$urandom, $urandom, $urandom});
	endtask
	// Bounded poll; a flag that never rises shows up as a mismatch later
	task automatic wait_flag(input logic [7:0] a);
		for (int i = 0; i < 300; i++) begin
			repeat (100) @(posedge sys_clk);
			acr_host_model_inst.rd(a, d);
			if (d[0] === 1'b1) break;
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hf1d2));
		{ux, uy, uz, fx, fy, fz} = 84'({$urandom, $urandom, $urandom});
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		rdc("range", 8'h0F, 8'h03);
		rdc("bw", 8'h10, 8'h0F);
		rdc("ctrl", 8'h13, 8'h00);
		rdc("softrst", 8'h14, 8'h00);
		rdc("hole", 8'h20, 8'h00);
		rdc("x low", 8'h02, 8'h00);
		chk("ready", 8'h01, {7'h00, sample_ready});
		r = 8'($urandom);
		temp_in <= r;
		rdc("temp", 8'h08, r);
		$display("reset and temp done");
		for (int i = 0; i < 4; i++) begin
			r = 8'($urandom);
			wr(8'h0F, r);
			wr(8'h10, r);
			wr(8'h13, r);
			rdc("range", 8'h0F, {4'h0, r[3:0]});
			rdc("bw", 8'h10, {3'h0, r[4:0]});
			rdc("ctrl", 8'h13, {r[7:6], 6'h00});
			chk("bw port", {3'h0, r[4:0]}, {3'h0, bw_code});
			chk("range port", {4'h0, r[3:0]}, {4'h0, range_code});
			chk("sel port", {7'h00, r[7]}, {7'h00, unfiltered_stream_select});
		end
		$display("config done");
		wr(8'h13, 8'h80);
		fresh();
		wait_flag(8'h02);
		t_first = $time;
		chk("x low", lo(ux, 1'b1), d);
		rdc("x high", 8'h03, ux[13:6]);
		rdc("x flag", 8'h02, lo(ux, 1'b0));
		rdc("y high", 8'h05, uy[13:6]);
		rdc("y flag", 8'h04, lo(uy, 1'b0));
		rdc("z low", 8'h06, lo(uz, 1'b1));
		rdc("z high", 8'h07, uz[13:6]);
		$display("sample done");
		s = ux;
		rdc("x low", 8'h02, lo(ux, 1'b0));
		fresh();
		wait_flag(8'h04);
		// Poll jitter is about 100 cycles on either detection
		r = 8'(($time - t_first) > 495000
			&& ($time - t_first) < 505000);
		chk("period", 8'h01, r);
		rdc("x locked", 8'h03, s[13:6]);
		rdc("x after", 8'h02, lo(ux, 1'b0));
		rdc("x pair", 8'h03, ux[13:6]);
		wr(8'h10, 8'h15);
		wr(8'h13, 8'h40);
		rdc("x low", 8'h02, lo(ux, 1'b0));
		fresh();
		wait_flag(8'h04);
		rdc("x live", 8'h03, fx[13:6]);
		$display("shadow done");
		wr(8'h0F, 8'h05);
		wr(8'h14, 8'h55);
		rdc("range kept", 8'h0F, 8'h05);
		wr(8'h14, 8'hB6);
		rdc("range", 8'h0F, 8'h03);
		rdc("bw", 8'h10, 8'h0F);
		rdc("ctrl", 8'h13, 8'h00);
		rdc("x low", 8'h02, 8'h00);
		rdc("x high", 8'h03, 8'h00);
		$display("soft reset done");
		end_sim();
	end
	initial begin
		repeat (100000) @(posedge sys_clk);
		n_errors++;
		end_sim();
	end
endmodule // acr_readout_bench
bind acr_readout acr_readout_checker acr_readout_checker_inst (.sys_clk, .rst,
	.reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .temp_in, .range_code,
	.bw_code, .unfiltered_stream_select);

//--- verilog/acr_cfg.svh
// Purpose: constants for the accelerometer register readout block
// Assumes: byte-wide register port, 40 MHz system clock
// Notes: offsets are register addresses on the serial port
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
`define ACR_ADDR_X_LOW 8'h02
`define ACR_ADDR_X_HIGH 8'h03
`define ACR_ADDR_Y_LOW 8'h04
`define ACR_ADDR_Y_HIGH 8'h05
`define ACR_ADDR_Z_LOW 8'h06
`define ACR_ADDR_Z_HIGH 8'h07
`define ACR_ADDR_TEMP 8'h08
`define ACR_ADDR_RANGE 8'h0F
`define ACR_ADDR_BW 8'h10
`define ACR_ADDR_CTRL 8'h13
`define ACR_ADDR_SOFTRST 8'h14
`define ACR_SOFTRST_CODE 8'hB6
`define ACR_CTRL_SHADOW_DIS_BIT 6
`define ACR_CTRL_UNFILT_BIT 7
`define ACR_RANGE_RESET 4'h3
`define ACR_BW_RESET 5'h0F
`define ACR_CTRL_RESET 2'h0
`define ACR_BW_LOWEST 5'h08
`define ACR_BW_UNFILT 5'h0F
// Unfiltered sample period 0.5 ms, in ns, and in 25 ns clock cycles
`define ACR_CLK_PERIOD_NS 25
`define ACR_UNFILT_PERIOD_NS 500000
`define ACR_UNFILT_CYCLES (`ACR_UNFILT_PERIOD_NS / `ACR_CLK_PERIOD_NS)
`endif

//--- verilog/acr_pkg.sv
// Purpose: types for the accelerometer register readout block
// Assumes: nothing beyond the config header
// Notes: holds types only
package acr_pkg;
	typedef logic [13:0] acr_sample_t;
	typedef logic [7:0] acr_byte_t;
	typedef enum logic [1:0] {
		ACR_AXIS_X = 2'b00,
		ACR_AXIS_Y = 2'b01,
		ACR_AXIS_Z = 2'b10
	} acr_axis_t;
endpackage

//--- verilog/acr_rate_gen.sv
// Purpose: sample strobe generator for filtered and unfiltered streams
// Assumes: 40 MHz clock
// Notes: filtered period is 2^(15-code) times the unfiltered period for codes 8 to 15
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_rate_gen (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [4:0] bw_code,
	input wire logic unfilt_sel,
	output logic tick
);
	import acr_pkg::*;
	localparam int unsigned BASE = `ACR_UNFILT_CYCLES;
	logic [14:0] base_cnt_reg;
	logic [6:0] div_cnt_reg;
	logic base_tick;
	logic [2:0] shift;
	logic [6:0] div_mask;
	logic raw_bypass;
	// Reserved low codes act as the slowest filter, high codes bypass
	assign raw_bypass = unfilt_sel | bw_code[4] | (bw_code == `ACR_BW_UNFILT);
	assign shift = bw_code[3] ? (3'd7 - bw_code[2:0]) : 3'd7;
	assign div_mask = 7'((8'd1 << shift) - 8'd1);
	assign base_tick = (base_cnt_reg == 15'(BASE - 1));
	// Unfiltered stream runs at a fixed 2 kHz
	assign tick = base_tick & (raw_bypass | ((div_cnt_reg & div_mask) == 7'h00));
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			base_cnt_reg <= 15'h0000;
			div_cnt_reg <= 7'h00;
		end else begin
			base_cnt_reg <= base_tick ? 15'h0000 : base_cnt_reg + 15'h0001;
			if (base_tick)
				div_cnt_reg <= div_cnt_reg + 7'h01;
		end
	end
endmodule // acr_rate_gen

//--- verilog/acr_readout.sv
// Purpose: register file and sample readout of a three-axis accelerometer
// Assumes: byte register port driven by a serial front end, one access
//  per strobe; sample inputs already offset compensated by the filter path
// Notes: samples enter through a two-entry buffer; stalls while a read
//  is in progress so no sample is lost
`timescale 1ns/1ps
`include "acr_cfg.svh"
module acr_readout (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [13:0] filt_x,
	input wire logic [13:0] filt_y,
	input wire logic [13:0] filt_z,
	input wire logic [13:0] unfilt_x,
	input wire logic [13:0] unfilt_y,
	input wire logic [13:0] unfilt_z,
	input wire logic [7:0] temp_in,
	output logic sample_ready,
	output logic [3:0] range_code,
	output logic [4:0] bw_code,
	output logic unfiltered_stream_select
);
	import acr_pkg::*;

	// Configuration registers
	logic [3:0] range_reg;
	logic [4:0] bw_reg;
	logic shadow_dis_reg;
	logic unfilt_reg;
	logic [7:0] temp_reg;
	logic [7:0] rdata_reg;

	// Per-axis data
	acr_sample_t live_reg [3];
	logic [7:0] high_reg [3];
	logic lock_reg [3];
	logic flag_reg [3];
	logic undef_reg;

	// Decode
	logic wr_range;
	logic wr_bw;
	logic wr_ctrl;
	logic soft_rst;
	logic tick;
	logic src_valid;
	logic src_ready;
	logic buf_valid;
	logic buf_ready;
	logic [41:0] src_data;
	logic [41:0] buf_data;
	logic [2:0] rd_low;
	logic [2:0] rd_high;
	logic [7:0] rd_mux;

	assign wr_range = reg_wr & (reg_addr == `ACR_ADDR_RANGE);
	assign wr_bw = reg_wr & (reg_addr == `ACR_ADDR_BW);
	assign wr_ctrl = reg_wr & (reg_addr == `ACR_ADDR_CTRL);
	assign soft_rst = reg_wr & (reg_addr == `ACR_ADDR_SOFTRST)
		& (reg_wdata == `ACR_SOFTRST_CODE);

	assign range_code = range_reg;
	assign bw_code = bw_reg;
	assign unfiltered_stream_select = unfilt_reg;

	acr_rate_gen u_rate (
		.sys_clk(sys_clk),
		.rst(rst),
		.bw_code(bw_reg),
		.unfilt_sel(unfilt_reg),
		.tick(tick)
	);

	// Stream pick; offset compensation happens upstream of this block
	assign src_data = unfilt_reg ? {unfilt_z, unfilt_y, unfilt_x}
		: {filt_z, filt_y, filt_x};
	assign src_valid = tick;
	assign sample_ready = src_ready;

	acr_skid u_buf (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(src_valid),
		.in_ready(src_ready),
		.in_data(src_data),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data(buf_data)
	);

	// Hold samples back during a read so flag clear and update never collide
	assign buf_ready = ~reg_rd;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_axis
			localparam logic [7:0] LOW_ADDR = 8'(`ACR_ADDR_X_LOW + 2 * g);
			logic upd;
			acr_sample_t new_s;
			assign new_s = buf_data[14*g +: 14];
			assign upd = buf_valid & buf_ready;
			assign rd_low[g] = reg_rd & (reg_addr == LOW_ADDR);
			assign rd_high[g] = reg_rd & (reg_addr == LOW_ADDR + 8'h01);
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					live_reg[g] <= 14'h0000;
					high_reg[g] <= 8'h00;
					lock_reg[g] <= 1'b0;
					flag_reg[g] <= 1'b0;
				end else if (soft_rst) begin
					live_reg[g] <= 14'h0000;
					high_reg[g] <= 8'h00;
					lock_reg[g] <= 1'b0;
					flag_reg[g] <= 1'b0;
				end else begin
					if (upd)
						live_reg[g] <= new_s;
					// High byte follows the live sample unless locked
					if (upd && (!lock_reg[g] || shadow_dis_reg))
						high_reg[g] <= new_s[13:6];
					// A low read pins the high byte to the sample just read;
					// a release catches up with updates held back meanwhile
					else if (rd_low[g] || (lock_reg[g]
						&& (rd_high[g] || shadow_dis_reg)))
						high_reg[g] <= live_reg[g][13:6];
					if (rd_low[g] && !shadow_dis_reg)
						lock_reg[g] <= 1'b1;
					else if (rd_high[g] || shadow_dis_reg)
						lock_reg[g] <= 1'b0;
					if (upd)
						flag_reg[g] <= 1'b1;
					else if (rd_low[g] || rd_high[g])
						flag_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Undefined bit carries a free-running toggle; the host ignores it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			undef_reg <= 1'b0;
		else
			undef_reg <= ~undef_reg;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			range_reg <= `ACR_RANGE_RESET;
			bw_reg <= `ACR_BW_RESET;
			shadow_dis_reg <= 1'b0;
			unfilt_reg <= 1'b0;
			temp_reg <= 8'h00;
		end else begin
			temp_reg <= temp_in;
			if (soft_rst) begin
				range_reg <= `ACR_RANGE_RESET;
				bw_reg <= `ACR_BW_RESET;
				shadow_dis_reg <= 1'b0;
				unfilt_reg <= 1'b0;
			end else begin
				if (wr_range)
					range_reg <= reg_wdata[3:0];
				if (wr_bw)
					bw_reg <= reg_wdata[4:0];
				if (wr_ctrl) begin
					shadow_dis_reg <= reg_wdata[`ACR_CTRL_SHADOW_DIS_BIT];
					unfilt_reg <= reg_wdata[`ACR_CTRL_UNFILT_BIT];
				end
			end
		end
	end

	// Read mux; unmapped and write-only addresses read as zero
	always_comb begin
		rd_mux = 8'h00;
		case (reg_addr)
			`ACR_ADDR_X_LOW: rd_mux = {live_reg[0][5:0], undef_reg, flag_reg[0]};
			`ACR_ADDR_X_HIGH: rd_mux = high_reg[0];
			`ACR_ADDR_Y_LOW: rd_mux = {live_reg[1][5:0], undef_reg, flag_reg[1]};
			`ACR_ADDR_Y_HIGH: rd_mux = high_reg[1];
			`ACR_ADDR_Z_LOW: rd_mux = {live_reg[2][5:0], undef_reg, flag_reg[2]};
			`ACR_ADDR_Z_HIGH: rd_mux = high_reg[2];
			`ACR_ADDR_TEMP: rd_mux = temp_reg;
			`ACR_ADDR_RANGE: rd_mux = {4'h0, range_reg};
			`ACR_ADDR_BW: rd_mux = {3'h0, bw_reg};
			`ACR_ADDR_CTRL: rd_mux = {unfilt_reg, shadow_dis_reg, 6'h00};
			default: rd_mux = 8'h00;
		endcase
	end

	// Read data registered on the strobe and held until the next read
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			rdata_reg <= 8'h00;
		else if (reg_rd)
			rdata_reg <= rd_mux;
	end
	assign reg_rdata = rdata_reg;

endmodule // acr_readout

//--- verilog/acr_skid.sv
// Purpose: two-entry buffer for incoming sample triples
// Assumes: valid/ready handshake on both sides
// Notes: holds a word while the register file is busy with a read
`timescale 1ns/1ps
module acr_skid (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [41:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [41:0] out_data
);
	import acr_pkg::*;
	logic [41:0] mem_reg [2];
	logic rd_ptr_reg;
	logic wr_ptr_reg;
	logic [1:0] count_reg;
	logic push;
	logic pop;
	assign in_ready = (count_reg != 2'd2);
	assign out_valid = (count_reg != 2'd0);
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;
	assign out_data = mem_reg[rd_ptr_reg];
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rd_ptr_reg <= 1'b0;
			wr_ptr_reg <= 1'b0;
			count_reg <= 2'd0;
			mem_reg[0] <= 42'h0;
			mem_reg[1] <= 42'h0;
		end else begin
			if (push) begin
				mem_reg[wr_ptr_reg] <= in_data;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule // acr_skid
